// ### adcc_pkg.sv
package adcc_pkg;

    localparam int unsigned CLOCK_HZ          = 125_000_000;
    localparam int unsigned CLOCK_PERIOD_NS   = 8;

    // oscillator rates; the tick generator runs at twice these (half periods)
    localparam longint unsigned OSC_NORMAL_HZ = 1_024_000;
    localparam longint unsigned OSC_TURBO_HZ  = 2_048_000;
    localparam logic [31:0] HALF_INC_NORMAL =
        32'(((2 * OSC_NORMAL_HZ) << 32) / CLOCK_HZ);
    localparam logic [31:0] HALF_INC_TURBO =
        32'(((2 * OSC_TURBO_HZ) << 32) / CLOCK_HZ);

    // index of the last of four oscillator periods per modulator period
    localparam logic [1:0]  MOD_DIV_LAST      = 2'h3;

    // start delay in half oscillator periods: 28.5 and 105 periods
    localparam logic [16:0] START_DLY_NORMAL  = 17'h0_0039;
    localparam logic [16:0] START_DLY_TURBO   = 17'h0_00D2;

    // internal reference settling
    localparam int unsigned REF_SETTLE_NS     = 25_000;
    localparam logic [11:0] REF_SETTLE_CYC    =
        12'((REF_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

    // gain codes 0..7 mean 1..128
    localparam logic [2:0]  GAIN_X4           = 3'h2;

    // input selections that tie the negative input to the analog ground
    localparam logic [3:0]  SEL_GND_FIRST     = 4'h8;
    localparam logic [3:0]  SEL_GND_LAST      = 4'hB;

    localparam logic [1:0]  REF_INTERNAL      = 2'h0;
    localparam logic [1:0]  REF_EXTERNAL      = 2'h1;
    localparam logic [1:0]  REF_SUPPLY        = 2'h2;

    localparam logic [7:0]  CMD_POWERDOWN     = 8'h02;
    localparam logic [7:0]  CMD_START         = 8'h08;
    localparam logic [3:0]  CMD_LATCH_EDGE    = 4'h7;
    localparam logic [3:0]  CMD_EDGES_DONE    = 4'h8;

    localparam logic [2:0]  RATE_LAST         = 3'h6;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DELAY,
        ST_CONV
    } adcc_state_t;

    // continuous conversion time in oscillator periods
    function automatic logic [15:0] adcc_cont_periods(input logic [2:0] rate);
        unique case (rate)
            3'h0:    adcc_cont_periods = 16'hC7F8;
            3'h1:    adcc_cont_periods = 16'h58FC;
            3'h2:    adcc_cont_periods = 16'h2D0C;
            3'h3:    adcc_cont_periods = 16'h171C;
            3'h4:    adcc_cont_periods = 16'h0C2C;
            3'h5:    adcc_cont_periods = 16'h06BC;
            default: adcc_cont_periods = 16'h040C;
        endcase
    endfunction : adcc_cont_periods

    // single-shot conversion time in oscillator periods
    function automatic logic [15:0] adcc_ss_periods(input logic [2:0] rate,
                                                    input logic       turbo);
        unique case (rate)
            3'h0:    adcc_ss_periods = turbo ? 16'hC811 : 16'hC80D;
            3'h1:    adcc_ss_periods = turbo ? 16'h5919 : 16'h5915;
            3'h2:    adcc_ss_periods = turbo ? 16'h2D29 : 16'h2D25;
            3'h3:    adcc_ss_periods = turbo ? 16'h1739 : 16'h1735;
            3'h4:    adcc_ss_periods = turbo ? 16'h0C49 : 16'h0C45;
            3'h5:    adcc_ss_periods = turbo ? 16'h06D9 : 16'h06D5;
            default: adcc_ss_periods = turbo ? 16'h0429 : 16'h0425;
        endcase
    endfunction : adcc_ss_periods

endpackage : adcc_pkg

// ### adcc_tick_gen.sv
module adcc_tick_gen
    import adcc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        restart,
    input  wire logic [31:0] increment,
    output logic             tick
);

    logic [31:0] acc_q;
    logic [32:0] sum;

    assign sum = {1'b0, acc_q} + {1'b0, increment};

    // phase accumulator; carry out marks one tick
    always_ff @(posedge clock) begin
        if (reset || restart) begin
            acc_q <= 32'h0000_0000;
            tick  <= 1'b0;
        end else begin
            acc_q <= sum[31:0];
            tick  <= sum[32];
        end
    end

endmodule : adcc_tick_gen

// ### adcc_core.sv
// How it works
// - skip bit with gain 1, 2 or 4 bypasses and disables the amplifier
// - input selections 8 to 11 always bypass and disable the amplifier
// - with those selections any gain above 4 is applied as 4
// - two-bit reference select picks internal, external pair or supply
// - reset leaves the internal reference selected
// - modulator clock is the oscillator divided by four
// - oscillator 1.024 MHz normal, 2.048 MHz turbo
// - every conversion yields a settled result, none discarded
// - continuous period spans falling edges of result ready
// - first continuous conversion starts 28.5 or 105 periods after start latch
// - continuous period excludes the initial start delay
// - single-shot time runs from start latch to result ready falling
// - commands latch on eighth falling serial clock edge of byte
// - continuous times per rate from 51192 down to 1036 periods
// - single-shot times per rate and mode from table
// - single-shot converts once then sleeps; continuous restarts at once
module adcc_core
    import adcc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       scl,
    input  wire logic       cmd_byte_begin,
    input  wire logic [7:0] cmd_byte,
    input  wire logic       result_read,
    input  wire logic [2:0] gain_setting,
    input  wire logic       amp_skip_bit,
    input  wire logic [3:0] input_select,
    input  wire logic [1:0] ref_select,
    input  wire logic       turbo_mode,
    input  wire logic       continuous_mode,
    input  wire logic [2:0] rate_select,
    output logic            amp_enable_q,
    output logic            amp_bypass_q,
    output logic [2:0]      eff_gain_q,
    output logic [1:0]      ref_sel_q,
    output logic            ref_settling_q,
    output logic            mod_clk_en_q,
    output logic            converting_q,
    output logic            low_power_q,
    output logic            result_store_q,
    output logic            result_ready_n_q
);

    localparam int NORM_GAP_MIN  = 121;
    localparam int NORM_GAP_MAX  = 122;
    localparam int TURBO_GAP_MIN = 60;
    localparam int TURBO_GAP_MAX = 61;

    logic        scl_meta_q;
    logic        scl_sync_q;
    logic        scl_prev_q;
    logic        scl_fall;
    logic [3:0]  edge_cnt_q;
    logic        cmd_latch;
    logic        start_latch;
    logic        pd_latch;
    logic        half_tick;
    logic        half_ph_q;
    logic        osc_tick;
    logic [1:0]  mod_ph_q;
    logic        gnd_sel;
    logic [11:0] settle_cnt_q;
    adcc_state_t state_q;
    logic [16:0] cnt_q;
    logic        cont_q;
    logic        turbo_q;
    logic [2:0]  rate_q;
    logic [2:0]  rate_lim;
    logic        step_done;
    logic        conv_done;

    // serial clock pin enters through two flops
    always_ff @(posedge clock) begin
        if (reset) begin
            scl_meta_q <= 1'b1;
            scl_sync_q <= 1'b1;
            scl_prev_q <= 1'b1;
        end else begin
            scl_meta_q <= scl;
            scl_sync_q <= scl_meta_q;
            scl_prev_q <= scl_sync_q;
        end
    end

    assign scl_fall = scl_prev_q & ~scl_sync_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            edge_cnt_q <= CMD_EDGES_DONE;
        end else if (cmd_byte_begin) begin
            edge_cnt_q <= 4'h0;
        end else if (scl_fall && edge_cnt_q != CMD_EDGES_DONE) begin
            edge_cnt_q <= edge_cnt_q + 4'h1;
        end
    end

    assign cmd_latch   = scl_fall && (edge_cnt_q == CMD_LATCH_EDGE);
    assign start_latch = cmd_latch && (cmd_byte == CMD_START);
    assign pd_latch    = cmd_latch && (cmd_byte == CMD_POWERDOWN);

    // oscillator half-period ticks, phase aligned to the start latch
    adcc_tick_gen u_tick (
        .clock     (clock),
        .reset     (reset),
        .restart   (start_latch),
        .increment (turbo_q ? HALF_INC_TURBO : HALF_INC_NORMAL),
        .tick      (half_tick)
    );

    assign osc_tick = half_tick && half_ph_q;

    always_ff @(posedge clock) begin
        if (reset || start_latch) begin
            half_ph_q <= 1'b0;
        end else if (half_tick) begin
            half_ph_q <= ~half_ph_q;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            mod_ph_q     <= 2'h0;
            mod_clk_en_q <= 1'b0;
        end else begin
            if (osc_tick) begin
                mod_ph_q <= mod_ph_q + 2'h1;
            end
            mod_clk_en_q <= osc_tick && (mod_ph_q == MOD_DIV_LAST);
        end
    end

    // amplifier bypass and gain limit
    assign gnd_sel = (input_select >= SEL_GND_FIRST) &&
                     (input_select <= SEL_GND_LAST);

    always_ff @(posedge clock) begin
        if (reset) begin
            amp_bypass_q <= 1'b0;
            amp_enable_q <= 1'b1;
            eff_gain_q   <= 3'h0;
        end else begin
            amp_bypass_q <= gnd_sel ||
                            (amp_skip_bit && gain_setting <= GAIN_X4);
            amp_enable_q <= !(gnd_sel ||
                              (amp_skip_bit && gain_setting <= GAIN_X4));
            eff_gain_q   <= (gnd_sel && gain_setting > GAIN_X4) ?
                            GAIN_X4 : gain_setting;
        end
    end

    // reference select and internal reference settling window
    always_ff @(posedge clock) begin
        if (reset) begin
            ref_sel_q <= REF_INTERNAL;
        end else begin
            ref_sel_q <= ref_select;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            settle_cnt_q   <= REF_SETTLE_CYC;
            ref_settling_q <= 1'b1;
        end else begin
            if ((ref_sel_q == REF_EXTERNAL && ref_select == REF_INTERNAL) ||
                (start_latch && low_power_q)) begin
                settle_cnt_q <= REF_SETTLE_CYC;
            end else if (settle_cnt_q != 12'h000) begin
                settle_cnt_q <= settle_cnt_q - 12'h001;
            end
            ref_settling_q <= settle_cnt_q != 12'h000;
        end
    end

    // conversion sequencing, counted in oscillator half periods
    assign rate_lim  = (rate_select > RATE_LAST) ? RATE_LAST : rate_select;
    assign step_done = half_tick && (cnt_q == 17'h0_0001);
    assign conv_done = step_done && (state_q == ST_CONV);

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cnt_q   <= 17'h0_0000;
            cont_q  <= 1'b0;
            turbo_q <= 1'b0;
            rate_q  <= 3'h0;
        end else if (pd_latch) begin
            state_q <= ST_IDLE;
        end else if (start_latch) begin
            cont_q  <= continuous_mode;
            turbo_q <= turbo_mode;
            rate_q  <= rate_lim;
            if (continuous_mode) begin
                state_q <= ST_DELAY;
                cnt_q   <= turbo_mode ? START_DLY_TURBO
                                      : START_DLY_NORMAL;
            end else begin
                state_q <= ST_CONV;
                cnt_q   <= {adcc_ss_periods(rate_lim, turbo_mode),
                            1'b0};
            end
        end else if (state_q != ST_IDLE && half_tick) begin
            if (step_done) begin
                if (state_q == ST_DELAY || cont_q) begin
                    state_q <= ST_CONV;
                    cnt_q   <= {adcc_cont_periods(rate_q),
                                1'b0};
                end else begin
                    state_q <= ST_IDLE;
                end
            end else begin
                cnt_q <= cnt_q - 17'h0_0001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            converting_q   <= 1'b0;
            low_power_q    <= 1'b1;
            result_store_q <= 1'b0;
        end else begin
            converting_q   <= (state_q != ST_IDLE) && !pd_latch &&
                              !(conv_done && !cont_q);
            // the filter settles in one cycle, so every result is kept
            result_store_q <= conv_done;
            if (pd_latch || (conv_done && !cont_q)) begin
                low_power_q <= 1'b1;
            end else if (start_latch) begin
                low_power_q <= 1'b0;
            end
        end
    end

    // store beats read; released one half tick early so each store falls
    always_ff @(posedge clock) begin
        if (reset) begin
            result_ready_n_q <= 1'b1;
        end else if (conv_done) begin
            result_ready_n_q <= 1'b0;
        end else if (result_read || start_latch ||
                     (state_q == ST_CONV && half_tick &&
                      cnt_q == 17'h0_0002)) begin
            result_ready_n_q <= 1'b1;
        end
    end

    // helper counters watched only by the checks below
    logic [16:0] ht_latch_q;
    logic [16:0] ht_store_q;
    logic        store_seen_q;
    logic [7:0]  osc_gap_q;
    logic        osc_seen_q;
    logic [2:0]  osc_per_mod_q;
    logic        mod_seen_q;

    always_ff @(posedge clock) begin
        if (reset || start_latch) begin
            ht_latch_q   <= 17'h0_0000;
            ht_store_q   <= 17'h0_0000;
            store_seen_q <= 1'b0;
            osc_gap_q    <= 8'h00;
            osc_seen_q   <= 1'b0;
        end else begin
            if (half_tick && ht_latch_q != 17'h1_FFFF) begin
                ht_latch_q <= ht_latch_q + 17'h0_0001;
            end
            if (conv_done) begin
                ht_store_q   <= 17'h0_0000;
                store_seen_q <= 1'b1;
            end else if (half_tick) begin
                ht_store_q <= ht_store_q + 17'h0_0001;
            end
            osc_gap_q  <= osc_tick ? 8'h00 : osc_gap_q + 8'h01;
            osc_seen_q <= osc_seen_q || osc_tick;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            osc_per_mod_q <= 3'h0;
            mod_seen_q    <= 1'b0;
        end else if (mod_clk_en_q) begin
            osc_per_mod_q <= 3'h0;
            mod_seen_q    <= 1'b1;
        end else if (osc_tick) begin
            osc_per_mod_q <= osc_per_mod_q + 3'h1;
        end
    end

    sequence s_delay_ends;
        state_q == ST_DELAY && step_done;
    endsequence

    sequence s_single_done;
        conv_done && !cont_q;
    endsequence

    a_skip_bypass: assert property (@(posedge clock) disable iff (reset)
        amp_skip_bit && gain_setting <= GAIN_X4 |=>
        amp_bypass_q && !amp_enable_q)
        else $error("skip bit did not bypass amplifier");

    a_ground_bypass: assert property (@(posedge clock) disable iff (reset)
        gnd_sel |=> amp_bypass_q && !amp_enable_q)
        else $error("ground selection did not bypass amplifier");

    a_gain_clamp: assert property (@(posedge clock) disable iff (reset)
        gnd_sel && gain_setting > GAIN_X4 |=> eff_gain_q == GAIN_X4)
        else $error("gain not limited to four");

    a_ref_after_reset: assert property (@(posedge clock) disable iff (reset)
        $past(reset) |-> ref_sel_q == REF_INTERNAL)
        else $error("reference not internal after reset");

    a_mod_div_four: assert property (@(posedge clock) disable iff (reset)
        mod_clk_en_q && mod_seen_q |-> osc_per_mod_q == 3'h4)
        else $error("modulator enable not every fourth period");

    a_osc_rate: assert property (@(posedge clock) disable iff (reset)
        osc_tick && osc_seen_q && !start_latch |->
        (turbo_q ? (osc_gap_q >= TURBO_GAP_MIN && osc_gap_q <= TURBO_GAP_MAX)
                 : (osc_gap_q >= NORM_GAP_MIN && osc_gap_q <= NORM_GAP_MAX)))
        else $error("oscillator period out of range");

    a_start_delay: assert property (@(posedge clock) disable iff (reset)
        s_delay_ends |-> ht_latch_q + 17'h0_0001 ==
        (turbo_q ? START_DLY_TURBO : START_DLY_NORMAL))
        else $error("wrong delay before first conversion");

    a_cont_period: assert property (@(posedge clock) disable iff (reset)
        conv_done && cont_q && store_seen_q |->
        ht_store_q + 17'h0_0001 == {adcc_cont_periods(rate_q), 1'b0})
        else $error("wrong continuous conversion period");

    a_single_time: assert property (@(posedge clock) disable iff (reset)
        s_single_done |-> ht_latch_q + 17'h0_0001 ==
        {adcc_ss_periods(rate_q, turbo_q), 1'b0})
        else $error("wrong single-shot conversion time");

    a_single_sleep: assert property (@(posedge clock) disable iff (reset)
        s_single_done ##1 !start_latch |-> low_power_q && !converting_q)
        else $error("single shot did not enter low power");

    a_ready_falls: assert property (@(posedge clock) disable iff (reset)
        conv_done |=> !result_ready_n_q && result_store_q)
        else $error("result ready did not fall on store");

    a_ready_rises: assert property (@(posedge clock) disable iff (reset)
        result_read && !conv_done |=> result_ready_n_q)
        else $error("result ready not released on read");

endmodule : adcc_core

// ### adcc_host_model.sv
module adcc_host_model (
    input  wire logic       clock,
    output logic            scl,
    output logic            cmd_byte_begin,
    output logic [7:0]      cmd_byte,
    output logic            result_read
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl            = 1'h1;
        cmd_byte_begin = 1'h0;
        cmd_byte       = 8'h00;
        result_read    = 1'h0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_cyc

    // one command byte: eight falls of the serial clock, idle high between
    task automatic send_cmd(input logic [7:0] code);
        wait_cyc(1);
        cmd_byte_begin = 1'h1;
        cmd_byte       = code;
        wait_cyc(1);
        cmd_byte_begin = 1'h0;
        for (int i = 0; i < 8; i++) begin
            scl = 1'h0;
            wait_cyc(16);
            if (i < 7) begin
                scl = 1'h1;
                wait_cyc(16);
            end
        end
        scl      = 1'h1;
        // released byte no longer shows the command
        cmd_byte = ~code;
        wait_cyc(16);
    endtask : send_cmd

    task automatic read_result();
        wait_cyc(1);
        result_read = 1'h1;
        wait_cyc(1);
        result_read = 1'h0;
    endtask : read_result
endmodule : adcc_host_model

// ### tb.sv
module tb;
    import adcc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [2:0] gain;
        logic       skip;
        logic [3:0] sel;
        logic [1:0] rsel;
        logic       byp;
        logic [2:0] eg;
    } adcc_row_t;

    logic       clock, reset, scl, cmd_byte_begin, result_read;
    logic [7:0] cmd_byte;
    logic [2:0] gain_setting, rate_select, eff_gain_q;
    logic       amp_skip_bit, turbo_mode, continuous_mode;
    logic [3:0] input_select;
    logic [1:0] ref_select, ref_sel_q;
    logic       amp_enable_q, amp_bypass_q, ref_settling_q, mod_clk_en_q;
    logic       converting_q, low_power_q, result_store_q, result_ready_n_q;
    int         err_total = 0, n_checks = 0, cyc = 0, t = 0;
    adcc_row_t  rows [8];

    adcc_core u_adcc_core (
        .clock(clock), .reset(reset), .scl(scl),
        .cmd_byte_begin(cmd_byte_begin), .cmd_byte(cmd_byte),
        .result_read(result_read), .gain_setting(gain_setting),
        .amp_skip_bit(amp_skip_bit), .input_select(input_select),
        .ref_select(ref_select), .turbo_mode(turbo_mode),
        .continuous_mode(continuous_mode), .rate_select(rate_select),
        .amp_enable_q(amp_enable_q), .amp_bypass_q(amp_bypass_q),
        .eff_gain_q(eff_gain_q), .ref_sel_q(ref_sel_q),
        .ref_settling_q(ref_settling_q), .mod_clk_en_q(mod_clk_en_q),
        .converting_q(converting_q), .low_power_q(low_power_q),
        .result_store_q(result_store_q),
        .result_ready_n_q(result_ready_n_q)
    );

    adcc_host_model u_adcc_host_model (
        .clock(clock), .scl(scl), .cmd_byte_begin(cmd_byte_begin),
        .cmd_byte(cmd_byte), .result_read(result_read)
    );

    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) cyc <= cyc + 1;

    task automatic end_sim();
        if (err_total == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask : chk

    task automatic chk_rng(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     lo);
        end
    endtask : chk_rng

    // 0: result ready low, 1: reference settled, 2: modulator pulse
    task automatic wait_on(input int which, input int bound);
        int k;
        k = 0;
        while (!((which == 0 && result_ready_n_q === 1'h0) ||
                 (which == 1 && ref_settling_q === 1'h0) ||
                 (which == 2 && mod_clk_en_q === 1'h1))) begin
            if (k == bound) begin
                err_total++;
                end_sim();
            end
            k++;
            step(1);
        end
    endtask : wait_on

    // span of ten modulator periods in system clocks
    task automatic mod_span(input int lo, input int hi);
        int t0;
        wait_on(2, 1000);
        t0 = cyc;
        repeat (10) begin
            step(1);
            wait_on(2, 1000);
        end
        chk_rng(cyc - t0, lo, hi);
    endtask : mod_span

    initial begin
        rows = '{'{3'h0, 1'h1, 4'h0, 2'h0, 1'h1, 3'h0},
                 '{3'h2, 1'h1, 4'h0, 2'h1, 1'h1, 3'h2},
                 '{3'h3, 1'h1, 4'h0, 2'h2, 1'h0, 3'h3},
                 '{3'h5, 1'h0, 4'h8, 2'h3, 1'h1, 3'h2},
                 '{3'h7, 1'h0, 4'hB, 2'h0, 1'h1, 3'h2},
                 '{3'h1, 1'h0, 4'hC, 2'h2, 1'h0, 3'h1},
                 '{3'h7, 1'h1, 4'h7, 2'h1, 1'h0, 3'h7},
                 '{3'h1, 1'h0, 4'h9, 2'h2, 1'h1, 3'h1}};
        reset           = 1'h1;
        gain_setting    = 3'h0;
        amp_skip_bit    = 1'h0;
        input_select    = 4'h0;
        ref_select      = 2'h0;
        turbo_mode      = 1'h0;
        continuous_mode = 1'h0;
        rate_select     = 3'h0;
        step(3);
        chk({converting_q, low_power_q, result_ready_n_q, ref_settling_q,
             ref_sel_q}, {1'h0, 1'h1, 1'h1, 1'h1, 2'h0});
        reset = 1'h0;
        t = cyc;
        wait_on(1, 4000);
        chk_rng(cyc - t, 3124, 3128);
        mod_span(4880, 4886);
        foreach (rows[i]) begin
            gain_setting = rows[i].gain;
            amp_skip_bit = rows[i].skip;
            input_select = rows[i].sel;
            ref_select   = rows[i].rsel;
            step(2);
            chk({amp_bypass_q, amp_enable_q, eff_gain_q},
                {rows[i].byp, ~rows[i].byp, rows[i].eg});
            chk(ref_sel_q, rows[i].rsel);
        end
        ref_select = 2'h1;
        step(2);
        ref_select = 2'h0;
        step(2);
        chk(ref_settling_q, 1'h1);
        wait_on(1, 3200);
        // single-ended input against ground, amplifier bypassed
        input_select = 4'h8;
        turbo_mode   = 1'h1;
        rate_select  = 3'h6;
        u_adcc_host_model.send_cmd(CMD_START);
        t = cyc - 32;
        chk({converting_q, low_power_q, amp_bypass_q}, 3'h5);
        mod_span(2439, 2444);
        wait_on(0, 70000);
        chk_rng(cyc - t, 64995, 65015);
        chk({result_store_q, converting_q, low_power_q}, 3'h5);
        step(1);
        chk({result_store_q, result_ready_n_q}, 2'h0);
        continuous_mode = 1'h1;
        rate_select     = 3'h7;
        u_adcc_host_model.send_cmd(CMD_START);
        t = cyc - 32;
        chk({result_ready_n_q, converting_q, low_power_q}, 3'h6);
        wait_on(0, 75000);
        chk_rng(cyc - t, 69635, 69655);
        chk({converting_q, result_store_q}, 2'h3);
        u_adcc_host_model.read_result();
        step(1);
        chk(result_ready_n_q, 1'h1);
        u_adcc_host_model.send_cmd(8'h55);
        chk({converting_q, low_power_q}, 2'h2);
        u_adcc_host_model.send_cmd(CMD_POWERDOWN);
        chk({converting_q, low_power_q}, 2'h1);
        end_sim();
    end
endmodule : tb
